// ### design/flash_host.sv
// host controller issuing program, erase, read and reset to a NOR flash
`default_nettype none
module flash_host
#(
   parameter longint unsigned SECT_LOAD_CYC = flash_host_pkg::SECT_LOAD_CYC_DEF,
   parameter longint unsigned PROG_TMO_CYC  = flash_host_pkg::PROG_TMO_CYC_DEF,
   parameter longint unsigned SECT_TMO_CYC  = flash_host_pkg::SECT_TMO_CYC_DEF,
   parameter longint unsigned CHIP_TMO_CYC  = flash_host_pkg::CHIP_TMO_CYC_DEF
)
(
   input  wire logic                        ref_clk,
   input  wire logic                        rst_n,
   input  wire logic                        clk_en,
   input  wire logic                        req_valid,
   input  wire flash_host_pkg::host_req_s   req,
   input  wire logic                        ce_strobe,
   output logic                             req_ready,
   output logic                             done,
   output logic                             fail,
   output flash_host_pkg::data_t            rd_data,
   output flash_host_pkg::flash_pins_s      flash_pins,
   input  wire flash_host_pkg::data_t       flash_dq_in,
   output logic                             flash_reset_n,
   input  wire logic                        ready_busy_n
);
   import flash_host_pkg::*;

   typedef enum logic [6:0] {
      S_IDLE     = 7'h01,
      S_SEQ      = 7'h02,
      S_SETTLE   = 7'h04,
      S_POLL     = 7'h08,
      S_RST_LOW  = 7'h10,
      S_RST_WAIT = 7'h20,
      S_DONE     = 7'h40
   } state_e;

   state_e           state_ff;
   state_e           nxt_state;
   logic [CNT_W-1:0] cnt_ff;
   logic [CNT_W-1:0] nxt_cnt;
   logic [CNT_W-1:0] tmo_ff;
   logic [CNT_W-1:0] nxt_tmo;
   logic [CNT_W-1:0] cnt_inc;
   logic [CNT_W-1:0] settle_cyc;
   logic [CNT_W-1:0] tmo_lim;
   logic [CNT_W-1:0] wait_cyc;
   logic [2:0]       step_ff;
   logic [2:0]       nxt_step;
   logic [2:0]       last_idx;
   host_req_s        cur_ff;
   logic             pend_ff;
   logic             running_ff;
   logic             nxt_running;
   logic             active_ff;
   logic             fail_ff;
   logic             nxt_fail;
   logic             prev6_ff;
   logic             have_prev_ff;
   logic             rb_meta_ff;
   logic             rb_sync_ff;
   logic             done_ff;
   logic             ready_ff;
   logic             rstn_out_ff;
   data_t            rd_data_ff;
   logic             bus_ready;
   data_t            bus_rd_data;
   bus_req_s         bus_req;
   bus_req_s         seq_req;
   addr_t            sector_addr;
   addr_t            poll_addr;
   logic             in_seq;
   logic             in_poll;
   logic             is_read;
   logic             issue;
   logic             step_end;
   logic             toggled;
   logic             dq7_want;
   logic             poll_ok;
   logic [7:0]       low_cnt_ff;
   logic [7:0]       high_cnt_ff;
   bus_req_s         last_wr_ff;

   // unlock cycles, then the op code, then the address/data, or for erase a second unlock pair and the go cycle
   function automatic bus_req_s seq_word(host_req_s r, logic [2:0] i,
                                         addr_t sect);
      bus_req_s w;
      logic     prog;
      w = '{write: 1'b1, addr: UNLOCK_A1, data: CMD_UNLOCK1};
      prog = r.op == OP_PROGRAM;
      case (i)
         3'h1, 3'h4:
         begin
            w.addr = UNLOCK_A2;
            w.data = CMD_UNLOCK2;
         end
         3'h2: w.data = prog ? CMD_PROGRAM : CMD_ERASE;
         3'h3:
            if (prog)
            begin
               w.addr = r.addr;
               w.data = r.data;
            end
         3'h5:
            if (r.op == OP_CHIP_ERASE)
               w.data = CMD_CHIP_GO;
            else
            begin
               w.addr = sect;
               w.data = CMD_SECTOR_GO;
            end
         default: w.write = 1'b1;
      endcase
      return w;
   endfunction

   assign in_seq      = state_ff == S_SEQ;
   assign in_poll     = state_ff == S_POLL;
   assign is_read     = cur_ff.op == OP_READ;
   assign issue       = bus_ready && !pend_ff && (in_seq || in_poll);
   assign step_end    = bus_ready && pend_ff;
   assign last_idx    = is_read ? 3'h0 :
                        (cur_ff.op == OP_PROGRAM ? 3'h3 : 3'h5);
   assign sector_addr = {cur_ff.addr[17:SECTOR_LSB], 12'h000};
   assign poll_addr   = (cur_ff.op == OP_SECTOR_ERASE) ? sector_addr
                                                       : cur_ff.addr;
   assign seq_req     = seq_word(cur_ff, step_ff, sector_addr);
   assign bus_req     = (in_poll || is_read) ?
                        bus_req_s'{write: 1'b0, addr: poll_addr,
                                   data: 16'h0000} : seq_req;
   // poll_ok only when the toggle has stopped, bit 7 settled and pin ready;
   // no verify read follows, the flash checks its own cells
   assign toggled  = have_prev_ff &&
                     (bus_rd_data[DQ_TOGGLE] != prev6_ff);
   assign dq7_want = (cur_ff.op == OP_PROGRAM) ? cur_ff.data[DQ_POLL]
                                               : 1'b1;
   assign poll_ok  = have_prev_ff && !toggled && rb_sync_ff &&
                     (bus_rd_data[DQ_POLL] == dq7_want);
   // sector erase starts only after the load window, so wait it out
   assign settle_cyc = (cur_ff.op == OP_SECTOR_ERASE) ?
                       CNT_W'(SECT_LOAD_CYC) : CNT_W'(BUSY_CYC);
   assign tmo_lim  = (cur_ff.op == OP_PROGRAM) ? CNT_W'(PROG_TMO_CYC) :
                     (cur_ff.op == OP_SECTOR_ERASE) ? CNT_W'(SECT_TMO_CYC)
                                                    : CNT_W'(CHIP_TMO_CYC);
   assign wait_cyc = running_ff ? CNT_W'(READY_ACT_CYC)
                                : CNT_W'(READY_IDLE_CYC);
   assign cnt_inc  = cnt_ff + 1'b1;

   assign req_ready     = ready_ff;
   assign done          = done_ff;
   assign fail          = fail_ff;
   assign rd_data       = rd_data_ff;
   assign flash_reset_n = rstn_out_ff;

   always_comb
   begin
      nxt_state   = state_ff;
      nxt_cnt     = cnt_ff;
      nxt_tmo     = tmo_ff;
      nxt_step    = step_ff;
      nxt_running = running_ff;
      nxt_fail    = fail_ff;
      case (state_ff)
         S_IDLE:
            if (req_valid)
            begin
               nxt_cnt   = '0;
               nxt_step  = 3'h0;
               nxt_fail  = 1'b0;
               nxt_state = (req.op == OP_RESET) ? S_RST_LOW : S_SEQ;
            end
         S_SEQ:
            if (step_end && step_ff == last_idx)
            begin
               nxt_cnt     = '0;
               nxt_tmo     = '0;
               nxt_running = !is_read;
               nxt_state   = is_read ? S_DONE : S_SETTLE;
            end
            else if (step_end)
               nxt_step = step_ff + 3'h1;
         S_SETTLE:
         begin
            nxt_cnt = cnt_inc;
            if (cnt_inc >= settle_cyc)
               nxt_state = S_POLL;
         end
         S_POLL:
         begin
            nxt_tmo = tmo_ff + 1'b1;
            if (step_end && poll_ok)
            begin
               nxt_running = 1'b0;
               nxt_state   = S_DONE;
            end
            else if (step_end && tmo_ff >= tmo_lim)
            begin
               nxt_fail  = 1'b1;
               nxt_cnt   = '0;
               nxt_state = S_RST_LOW;
            end
         end
         S_RST_LOW:
         begin
            nxt_cnt = cnt_inc;
            if (cnt_inc >= CNT_W'(RST_LOW_CYC))
            begin
               nxt_cnt   = '0;
               nxt_state = S_RST_WAIT;
            end
         end
         S_RST_WAIT:
         begin
            nxt_cnt = cnt_inc;
            if (cnt_inc >= wait_cyc)
            begin
               nxt_running = 1'b0;
               nxt_state   = S_DONE;
            end
         end
         S_DONE: nxt_state = S_IDLE;
         default: nxt_state = S_IDLE;
      endcase
   end

   // state of the flash is unknown at power-up, so reset it as if busy
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         state_ff   <= S_RST_LOW;
         cnt_ff     <= '0;
         tmo_ff     <= '0;
         step_ff    <= 3'h0;
         running_ff <= 1'b1;
         fail_ff    <= 1'b0;
      end
      else if (clk_en)
      begin
         state_ff   <= nxt_state;
         cnt_ff     <= nxt_cnt;
         tmo_ff     <= nxt_tmo;
         step_ff    <= nxt_step;
         running_ff <= nxt_running;
         fail_ff    <= nxt_fail;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         cur_ff       <= '{op: OP_READ, addr: 18'h00000, data: 16'h0000};
         pend_ff      <= 1'b0;
         active_ff    <= 1'b0;
         prev6_ff     <= 1'b0;
         have_prev_ff <= 1'b0;
         rb_meta_ff   <= 1'b1;
         rb_sync_ff   <= 1'b1;
         done_ff      <= 1'b0;
         ready_ff     <= 1'b0;
         rstn_out_ff  <= 1'b0;
         rd_data_ff   <= 16'h0000;
      end
      else if (clk_en)
      begin
         if (state_ff == S_IDLE && req_valid)
            cur_ff <= req;
         active_ff    <= (state_ff == S_IDLE && req_valid) ||
                         (active_ff && state_ff != S_DONE);
         pend_ff      <= issue || (pend_ff && !step_end);
         have_prev_ff <= in_poll && (have_prev_ff || step_end);
         if (in_poll && step_end)
            prev6_ff <= bus_rd_data[DQ_TOGGLE];
         rb_meta_ff   <= ready_busy_n;
         rb_sync_ff   <= rb_meta_ff;
         done_ff      <= state_ff == S_DONE && active_ff;
         ready_ff     <= nxt_state == S_IDLE;
         rstn_out_ff  <= nxt_state != S_RST_LOW;
         if (in_seq && is_read && step_end)
            rd_data_ff <= bus_rd_data;
      end
   end

   flash_bus_cycle flash_bus_cycle_inst
   (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n),
      .clk_en    (clk_en),
      .go        (issue),
      .req       (bus_req),
      .ce_strobe (ce_strobe),
      .dq_in     (flash_dq_in),
      .idle      (bus_ready),
      .rd_data   (bus_rd_data),
      .pins      (flash_pins)
   );

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         low_cnt_ff  <= 8'h00;
         high_cnt_ff <= 8'h00;
         last_wr_ff  <= '{write: 1'b0, addr: 18'h00000, data: 16'h0000};
      end
      else if (clk_en)
      begin
         low_cnt_ff  <= rstn_out_ff ? 8'h00 :
                        low_cnt_ff + {7'h00, low_cnt_ff != 8'hFF};
         high_cnt_ff <= !rstn_out_ff ? 8'h00 :
                        high_cnt_ff + {7'h00, high_cnt_ff != 8'hFF};
         if (issue && bus_req.write)
            last_wr_ff <= bus_req;
      end
   end

   sequence chip_go_write;
      issue && bus_req.write && bus_req.addr == UNLOCK_A1 &&
      bus_req.data == CMD_CHIP_GO;
   endsequence

   sequence unlock_tail_seen;
      last_wr_ff.addr == UNLOCK_A2 && last_wr_ff.data == CMD_UNLOCK2;
   endsequence

   a_chip_erase_tail:
   assert property (@(posedge ref_clk) disable iff (!rst_n)
      chip_go_write |-> unlock_tail_seen)
      else $error("chip erase go write not preceded by 55h at 2AAh");

   a_reset_low_width:
   assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(rstn_out_ff) |-> low_cnt_ff >= 8'(RST_LOW_CYC))
      else $error("flash reset released before 500 ns low");

   a_reset_high_read:
   assert property (@(posedge ref_clk) disable iff (!rst_n)
      $fell(flash_pins.oe_n) |-> high_cnt_ff >= 8'(RH_CYC))
      else $error("read started too soon after reset release");

   a_abort_on_timeout:
   assert property (@(posedge ref_clk) disable iff (!rst_n || !clk_en)
      $rose(fail_ff) |-> !rstn_out_ff ##1 !rstn_out_ff)
      else $error("timeout did not drive flash reset low");

   a_settle_no_read:
   assert property (@(posedge ref_clk) disable iff (!rst_n || !clk_en)
      $rose(state_ff == S_SETTLE) |-> flash_pins.oe_n [*8])
      else $error("status read issued inside the busy assert delay");

   a_done_pulse:
   assert property (@(posedge ref_clk) disable iff (!rst_n || !clk_en)
      done_ff |=> !done_ff)
      else $error("done held longer than one cycle");
endmodule
`default_nettype wire

// ### design/flash_host_pkg.sv
// package: flash host command codes, timing counts and carrier types
`default_nettype none
package flash_host_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int SYNC_STAGES   = 2;
   localparam int CNT_W         = 36;

   function automatic int cyc_ceil(int ns);
      return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   endfunction

   localparam longint unsigned CYC_PER_US = 64'(1000 / CLK_PERIOD_NS);
   localparam longint unsigned CYC_PER_S  = CYC_PER_US * 64'd1000000;

   localparam int T_WP_NS    = 35;
   localparam int T_WPH_NS   = 30;
   localparam int T_ACC_NS   = 70;
   localparam int T_BUSY_NS  = 90;
   localparam int T_RP_NS    = 500;
   localparam int T_RH_NS    = 50;
   localparam int T_RDY_IDLE_NS = 500;
   localparam int T_RDY_ACT_US  = 20;
   localparam int T_SECT_LOAD_US = 50;
   localparam int T_PROG_MAX_US  = 280;
   localparam int T_SECT_MAX_S   = 15;
   localparam int T_CHIP_MAX_S   = 120;

   localparam int TWP_CYC     = cyc_ceil(T_WP_NS);
   localparam int TWPH_CYC    = cyc_ceil(T_WPH_NS);
   localparam int RD_CYC      = cyc_ceil(T_ACC_NS) + SYNC_STAGES;
   localparam int BUSY_CYC    = cyc_ceil(T_BUSY_NS);
   localparam int RST_LOW_CYC = cyc_ceil(T_RP_NS);
   localparam int RH_CYC      = cyc_ceil(T_RH_NS);
   localparam int READY_ACT_CYC =
      cyc_ceil(T_RDY_ACT_US * 1000) - RST_LOW_CYC;
   localparam int READY_IDLE_CYC =
      (cyc_ceil(T_RDY_IDLE_NS) - RST_LOW_CYC > RH_CYC) ?
      cyc_ceil(T_RDY_IDLE_NS) - RST_LOW_CYC : RH_CYC;
   localparam longint unsigned SECT_LOAD_CYC_DEF =
      64'(T_SECT_LOAD_US) * CYC_PER_US;
   localparam longint unsigned PROG_TMO_CYC_DEF =
      64'(T_PROG_MAX_US) * CYC_PER_US;
   localparam longint unsigned SECT_TMO_CYC_DEF =
      64'(T_SECT_MAX_S) * CYC_PER_S;
   localparam longint unsigned CHIP_TMO_CYC_DEF =
      64'(T_CHIP_MAX_S) * CYC_PER_S;

   typedef logic [17:0] addr_t;
   typedef logic [15:0] data_t;

   localparam addr_t UNLOCK_A1 = 18'h00555;
   localparam addr_t UNLOCK_A2 = 18'h002AA;
   localparam data_t CMD_UNLOCK1   = 16'h00AA;
   localparam data_t CMD_UNLOCK2   = 16'h0055;
   localparam data_t CMD_PROGRAM   = 16'h00A0;
   localparam data_t CMD_ERASE     = 16'h0080;
   localparam data_t CMD_CHIP_GO   = 16'h0010;
   localparam data_t CMD_SECTOR_GO = 16'h0030;
   localparam int SECTOR_LSB = 12;
   localparam int DQ_TOGGLE  = 6;
   localparam int DQ_POLL    = 7;

   typedef enum logic [2:0] {
      OP_READ         = 3'h0,
      OP_PROGRAM      = 3'h1,
      OP_CHIP_ERASE   = 3'h2,
      OP_SECTOR_ERASE = 3'h3,
      OP_RESET        = 3'h4
   } op_e;

   typedef struct packed {
      op_e   op;
      addr_t addr;
      data_t data;
   } host_req_s;

   typedef struct packed {
      logic  write;
      addr_t addr;
      data_t data;
   } bus_req_s;

   typedef struct packed {
      addr_t addr;
      data_t dq_out;
      logic  dq_oe_n;
      logic  ce_n;
      logic  we_n;
      logic  oe_n;
   } flash_pins_s;

   localparam flash_pins_s PINS_IDLE = '{addr: 18'h00000, dq_out: 16'h0000,
      dq_oe_n: 1'b1, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1};
endpackage
`default_nettype wire

// ### design/flash_bus_cycle.sv
// single flash bus read or write cycle with selectable write strobe
`default_nettype none
module flash_bus_cycle
(
   input  wire logic                        ref_clk,
   input  wire logic                        rst_n,
   input  wire logic                        clk_en,
   input  wire logic                        go,
   input  wire flash_host_pkg::bus_req_s    req,
   input  wire logic                        ce_strobe,
   input  wire flash_host_pkg::data_t       dq_in,
   output logic                             idle,
   output flash_host_pkg::data_t            rd_data,
   output flash_host_pkg::flash_pins_s      pins
);
   import flash_host_pkg::*;

   typedef enum logic [4:0] {
      B_IDLE  = 5'h01,
      B_SETUP = 5'h02,
      B_PULSE = 5'h04,
      B_HOLD  = 5'h08,
      B_GAP   = 5'h10
   } bus_state_e;

   bus_state_e  st_ff;
   bus_state_e  nxt_st;
   logic [3:0]  cnt_ff;
   logic [3:0]  nxt_cnt;
   logic        wr_ff;
   logic        mode_ff;
   data_t       dq_meta_ff;
   data_t       dq_sync_ff;
   data_t       rd_ff;
   data_t       nxt_rd;
   flash_pins_s pins_ff;
   flash_pins_s nxt_pins;
   logic        pulse_end;
   logic        gap_end;

   assign pulse_end = cnt_ff == (wr_ff ? 4'(TWP_CYC - 1) : 4'(RD_CYC - 1));
   assign gap_end   = cnt_ff == 4'(TWPH_CYC - 1);
   assign idle      = st_ff == B_IDLE;
   assign rd_data   = rd_ff;
   assign pins      = pins_ff;

   // the leading strobe falls first so the other one ends the cycle
   always_comb
   begin
      nxt_st   = st_ff;
      nxt_cnt  = cnt_ff + 4'h1;
      nxt_pins = pins_ff;
      nxt_rd   = rd_ff;
      case (st_ff)
         B_IDLE:
         begin
            nxt_cnt = 4'h0;
            if (go)
            begin
               nxt_pins.addr    = req.addr;
               nxt_pins.dq_out  = req.data;
               nxt_pins.dq_oe_n = !req.write;
               nxt_pins.we_n    = !(req.write && ce_strobe);
               nxt_pins.ce_n    = req.write && ce_strobe;
               nxt_st           = B_SETUP;
            end
         end
         B_SETUP:
         begin
            nxt_cnt       = 4'h0;
            nxt_pins.ce_n = 1'b0;
            nxt_pins.we_n = !wr_ff;
            nxt_pins.oe_n = wr_ff;
            nxt_st        = B_PULSE;
         end
         B_PULSE:
            if (pulse_end)
            begin
               nxt_pins.we_n = !(mode_ff && wr_ff);
               nxt_pins.ce_n = mode_ff && wr_ff;
               nxt_pins.oe_n = 1'b1;
               if (!wr_ff)
                  nxt_rd = dq_sync_ff;
               nxt_st = B_HOLD;
            end
         B_HOLD:
         begin
            nxt_cnt          = 4'h0;
            nxt_pins.ce_n    = 1'b1;
            nxt_pins.we_n    = 1'b1;
            nxt_pins.dq_oe_n = 1'b1;
            nxt_st           = B_GAP;
         end
         B_GAP:
            if (gap_end)
               nxt_st = B_IDLE;
         default: nxt_st = B_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         st_ff      <= B_IDLE;
         cnt_ff     <= 4'h0;
         pins_ff    <= PINS_IDLE;
         rd_ff      <= 16'h0000;
         wr_ff      <= 1'b0;
         mode_ff    <= 1'b0;
         dq_meta_ff <= 16'h0000;
         dq_sync_ff <= 16'h0000;
      end
      else if (clk_en)
      begin
         st_ff      <= nxt_st;
         cnt_ff     <= nxt_cnt;
         pins_ff    <= nxt_pins;
         rd_ff      <= nxt_rd;
         dq_meta_ff <= dq_in;
         dq_sync_ff <= dq_meta_ff;
         if (idle && go)
         begin
            wr_ff   <= req.write;
            mode_ff <= ce_strobe;
         end
      end
   end

   a_we_strobe_mode:
   assert property (@(posedge ref_clk) disable iff (!rst_n)
      $fell(pins_ff.we_n) && !mode_ff |-> !pins_ff.ce_n)
      else $error("write strobe fell without chip enable low");

   a_ce_strobe_mode:
   assert property (@(posedge ref_clk) disable iff (!rst_n)
      $fell(pins_ff.ce_n) && mode_ff && wr_ff |-> !pins_ff.we_n)
      else $error("chip enable strobe fell without write strobe low");

   a_write_pulse:
   assert property (@(posedge ref_clk) disable iff (!rst_n || !clk_en)
      $fell(pins_ff.we_n) && wr_ff && !mode_ff |-> !pins_ff.we_n [*4])
      else $error("write strobe pulse shorter than four cycles");
endmodule
`default_nettype wire

// ### verification/flash_dev_model.sv
// behavioural word-wide flash device answering the host pins
`default_nettype none
module flash_dev_model
(
   input  wire logic                        ref_clk,
   input  wire flash_host_pkg::flash_pins_s pins,
   input  wire logic                        reset_n,
   input  wire logic                        slow,
   output flash_host_pkg::data_t            dq,
   output logic                             rb_n
);
   timeunit 1ns;
   timeprecision 1ns;
   import flash_host_pkg::*;
   data_t       mem [addr_t];
   logic [4:0][33:0] h = '0;
   logic [33:0] cur;
   logic        wr_q = 0, tog = 0, oe_q = 1, ers = 0;
   int          busy = 0;
   addr_t       pa;
   data_t       pd;
   // either strobe closes a write
   wire wr = !pins.ce_n && !pins.we_n;
   wire rd = !pins.ce_n && !pins.oe_n;
   // history word passed in so the nets follow every update of h
   function automatic logic m(logic [33:0] e, addr_t a, data_t d);
      return e == {a, d};
   endfunction
   wire u0 = m(h[1], UNLOCK_A1, CMD_UNLOCK1)
      && m(h[0], UNLOCK_A2, CMD_UNLOCK2);
   wire pgm = m(h[2], UNLOCK_A1, CMD_UNLOCK1)
      && m(h[1], UNLOCK_A2, CMD_UNLOCK2) && m(h[0], UNLOCK_A1, CMD_PROGRAM);
   wire ersq = m(h[4], UNLOCK_A1, CMD_UNLOCK1)
      && m(h[3], UNLOCK_A2, CMD_UNLOCK2)
      && m(h[2], UNLOCK_A1, CMD_ERASE) && u0;
   initial rb_n = 1'b1;
   always @(posedge ref_clk)
   begin
      if (wr)
         cur = {pins.addr, pins.dq_out};
      if (!reset_n)
      begin
         // abort drops the pending word
         busy = 0;
         h = '0;
      end
      else if (busy > 0)
      begin
         if (rd && oe_q)
            tog = !tog;
         busy = busy - 1;
         if (busy == 0 && !ers)
            mem[pa] = pd;
      end
      else if (wr_q && !wr)
      begin
         pa = cur[33:16];
         pd = cur[15:0];
         if (pgm)
         begin
            ers = 1'b0;
            busy = slow ? 5000 : 30;
         end
         else if (ersq && cur == {UNLOCK_A1, CMD_CHIP_GO})
         begin
            mem.delete();
            ers = 1'b1;
            busy = 60;
         end
         else if (ersq && pd == CMD_SECTOR_GO)
         begin
            // every stored word in the sector is set to FFFFh at once
            foreach (mem[a])
               if (a[17:12] == pa[17:12])
                  mem[a] = 16'hFFFF;
            ers = 1'b1;
            busy = 60;
         end
         h = busy > 0 ? '0 : {h[3:0], cur};
      end
      // released bus shows inverted last value
      dq <= !rd ? ~dq : busy > 0 ? {8'h00, ers ? 1'b0 : ~pd[7], tog, 6'h00}
         : mem.exists(pins.addr) ? mem[pins.addr] : 16'hFFFF;
      rb_n <= busy == 0;
      wr_q = wr;
      oe_q = pins.oe_n;
   end
endmodule
`default_nettype wire

// ### verification/flash_host_test.sv
// self-checking bench of the flash host against the device model
`default_nettype none
module flash_host_test;
   timeunit 1ns;
   timeprecision 1ns;
   import flash_host_pkg::*;
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; \
   $display("CHECK FAILED t=%0t value mismatch", $time); end end
   logic        ref_clk = 0, rst_n = 0, req_valid = 0, ce_strobe = 0;
   logic        slow = 0, saw_rst = 0, clk_en = 1;
   host_req_s   req = '0;
   logic        req_ready, done, fail, flash_reset_n, ready_busy_n;
   data_t       rd_data, flash_dq_in;
   flash_pins_s flash_pins;
   int          error_cnt = 0, n_tests = 0;
   always #5 ref_clk = ~ref_clk;
   always @(posedge ref_clk)
      if (flash_reset_n === 1'b0)
         saw_rst <= 1'b1;
   flash_host #(.SECT_LOAD_CYC(20), .PROG_TMO_CYC(200),
      .SECT_TMO_CYC(400), .CHIP_TMO_CYC(600)) flash_host_inst (.ref_clk,
      .rst_n, .clk_en, .req_valid, .req, .ce_strobe, .req_ready,
      .done, .fail, .rd_data, .flash_pins, .flash_dq_in, .flash_reset_n,
      .ready_busy_n);
   flash_dev_model flash_dev_model_inst (.ref_clk, .pins(flash_pins),
      .reset_n(flash_reset_n), .slow, .dq(flash_dq_in), .rb_n(ready_busy_n));
   task automatic report_and_stop;
      $display("errors=%0d checks=%0d", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // one request, bounded wait for its done pulse
   task automatic op(op_e o, addr_t a, data_t d, logic ce = 0);
      int k = 0;
      while (req_ready !== 1'b1 && k < 9000)
      begin
         @(posedge ref_clk);
         #1 k++;
      end
      @(posedge ref_clk);
      req_valid <= 1'b1;
      req <= '{o, a, d};
      ce_strobe <= ce;
      @(posedge ref_clk);
      req_valid <= 1'b0;
      do
      begin
         @(posedge ref_clk);
         #1 k++;
      end
      while (done !== 1'b1 && k < 9000);
      `CHK(k < 9000, 1'b1)
   endtask
   task automatic t_prog;
      op(OP_PROGRAM, 18'h01000, 16'h1234);
      `CHK(fail, 1'b0)
      op(OP_READ, 18'h01000, 16'h0000);
      `CHK(rd_data, 16'h1234)
      op(OP_PROGRAM, 18'h02003, 16'h00A5, 1'b1);
      op(OP_READ, 18'h02003, 16'h0000);
      `CHK(rd_data, 16'h00A5)
   endtask
   task automatic t_erase;
      op(OP_SECTOR_ERASE, 18'h01ABC, 16'h0000);
      `CHK(fail, 1'b0)
      op(OP_READ, 18'h01000, 16'h0000);
      `CHK(rd_data, 16'hFFFF)
      op(OP_READ, 18'h02003, 16'h0000);
      `CHK(rd_data, 16'h00A5)
      op(OP_CHIP_ERASE, 18'h00000, 16'h0000);
      `CHK(fail, 1'b0)
      op(OP_READ, 18'h02003, 16'h0000);
      `CHK(rd_data, 16'hFFFF)
   endtask
   // a stuck program must time out and pulse the flash reset
   task automatic t_abort;
      slow <= 1'b1;
      saw_rst <= 1'b0;
      op(OP_PROGRAM, 18'h03000, 16'h0F0F);
      slow <= 1'b0;
      `CHK(fail, 1'b1)
      `CHK(saw_rst, 1'b1)
      `CHK(ready_busy_n, 1'b1)
      op(OP_READ, 18'h03000, 16'h0000);
      `CHK(rd_data, 16'hFFFF)
      op(OP_RESET, 18'h00000, 16'h0000);
      `CHK(fail, 1'b0)
   endtask
   // a low clock enable must hold a read half way, pins and all
   task automatic t_freeze;
      flash_pins_s held;
      int          i;
      @(posedge ref_clk);
      req_valid <= 1'b1;
      req <= '{OP_READ, 18'h02003, 16'h0000};
      @(posedge ref_clk);
      req_valid <= 1'b0;
      repeat (6) @(posedge ref_clk);
      clk_en <= 1'b0;
      @(posedge ref_clk);
      #1 held = flash_pins;
      repeat (20) @(posedge ref_clk);
      #1 `CHK(flash_pins, held)
      `CHK(done, 1'b0)
      @(posedge ref_clk);
      clk_en <= 1'b1;
      i = 0;
      while (done !== 1'b1 && i < 100)
      begin
         @(posedge ref_clk);
         #1 i++;
      end
      `CHK(done, 1'b1)
      `CHK(rd_data, 16'h00A5)
   endtask
   initial
   begin
      repeat (10) @(posedge ref_clk);
      rst_n <= 1'b1;
      t_prog();
      t_freeze();
      t_erase();
      t_abort();
      report_and_stop();
   end
   initial
   begin
      #1000000;
      error_cnt++;
      report_and_stop();
   end
endmodule
`default_nettype wire
